// ---- src/scsc_clock_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scsc_defines.svh"

module scsc_clock_control
    import scsc_pkg::*;
#(
    parameter int PRE_STAGES = `SCSC_PRESCALE_STAGES,
    parameter int DIV_STAGES = `SCSC_DIVIDER_STAGES
)
(
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        periph_irq_in,
    input  wire logic        ext_irq_in,
    input  wire logic        watchdog_irq_in,
    input  wire logic        interrupt_master_enable_in,
    input  wire logic [3:0]  insn_cycles_in,
    input  wire logic        insn_start_in,
    output logic             insn_done_out,
    output logic             cpu_run_out,
    output logic             watchdog_run_out,
    output logic             periph_run_out,
    output logic             wake_vector_out,
    output logic             wake_resume_out,
    output logic             soft_reset_out,
    output logic             tbt_clk_out,
    output logic             watchdog_clk_out,
    output logic      [3:0]  tc_clk_out,
    output scsc_state_t      state_out,
    output scsc_mode_t       mode_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a == b);
    endfunction

    // the counter taps and the watchdog tap must exist in the chain
    generate
        if (PRE_STAGES < 2 || DIV_STAGES < `SCSC_TAP_WATCHDOG + 1)
        begin : g_bad_stages
            $error("scsc_clock_control: stage counts too small");
        end
    endgenerate

    // ------------------------------------------------------------
    // timing generator
    // ------------------------------------------------------------
    logic [PRE_STAGES-1:0] pre_w;
    logic [DIV_STAGES-1:0] div_w;
    scsc_state_t           st_w;
    logic                  cyc_end_w;

    scsc_timing_gen #(
        .PRE_STAGES (PRE_STAGES),
        .DIV_STAGES (DIV_STAGES)
    ) u_timing (
        .mclk_in       (mclk_in),
        .sys_rst_in    (sys_rst_in),
        .prescale_out  (pre_w),
        .divider_out   (div_w),
        .state_out     (st_w),
        .cycle_end_out (cyc_end_w)
    );

    // ------------------------------------------------------------
    // registers and mode state
    // ------------------------------------------------------------
    logic [7:0]  sc2_reg;
    logic [7:0]  sc2_next;
    logic [1:0]  divsel_reg;
    logic [1:0]  divsel_next;
    scsc_mode_t  mode_reg;
    scsc_mode_t  mode_next;
    logic        vec_reg;
    logic        vec_next;
    logic        res_reg;
    logic        res_next;
    logic        srst_reg;
    logic        srst_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic [3:0]  icnt_reg;
    logic [3:0]  icnt_next;
    logic        done_reg;
    logic        done_next;
    logic        tc_reg;
    logic        tc_next;
    logic [3:0]  tc_sel;
    logic        wake_w;
    logic        idle_req_w;

    assign wake_w     = periph_irq_in | ext_irq_in;
    assign idle_req_w = reg_wr_in && is_addr(reg_addr_in, `SCSC_ADDR_CTRL_TWO)
                        && reg_wdata_in[`SCSC_SC2_IDLE_BIT];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    localparam logic [1:0] DIVSEL_RST =
        2'(`SCSC_DIV_RESET_VALUE >> `SCSC_DIV_SEL_LSB);

    // the idle bit falls again when entry is refused or the wake is
    // taken, so a read-back cannot tell software whether idle was entered
    always_comb
    begin
        sc2_next    = sc2_reg;
        divsel_next = divsel_reg;
        srst_next   = 1'b0;
        if (reg_wr_in && is_addr(reg_addr_in, `SCSC_ADDR_CTRL_TWO))
        begin
            sc2_next = {1'b1, 2'b00, reg_wdata_in[`SCSC_SC2_IDLE_BIT], 4'h0};
            if (!reg_wdata_in[`SCSC_SC2_KEEP_BIT])
                srst_next = 1'b1;
        end
        if (reg_wr_in && is_addr(reg_addr_in, `SCSC_ADDR_DIVCTL))
            divsel_next = reg_wdata_in[`SCSC_DIV_SEL_MSB:`SCSC_DIV_SEL_LSB];
        if (mode_reg == SCSC_MODE_NORMAL && idle_req_w && watchdog_irq_in)
            sc2_next[`SCSC_SC2_IDLE_BIT] = 1'b0;
        if (mode_reg == SCSC_MODE_WAKE)
            sc2_next[`SCSC_SC2_IDLE_BIT] = 1'b0;
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sc2_reg    <= `SCSC_SC2_RESET_VALUE;
            divsel_reg <= DIVSEL_RST;
            srst_reg   <= 1'b0;
        end
        else
        begin
            sc2_reg    <= sc2_next;
            divsel_reg <= divsel_next;
            srst_reg   <= srst_next;
        end
    end

    // ------------------------------------------------------------
    // standby mode sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        vec_next  = 1'b0;
        res_next  = 1'b0;
        case (mode_reg)
            SCSC_MODE_NORMAL:
            begin
                // a watchdog interrupt already pending cancels entry
                if (idle_req_w && !watchdog_irq_in)
                    mode_next = SCSC_MODE_IDLE;
            end
            SCSC_MODE_IDLE:
            begin
                if (wake_w)
                    mode_next = SCSC_MODE_WAKE;
            end
            SCSC_MODE_WAKE:
            begin
                // master enable is looked at once, in the wake cycle
                mode_next = SCSC_MODE_NORMAL;
                vec_next  = interrupt_master_enable_in;
                res_next  = !interrupt_master_enable_in;
            end
            default:
            begin
                mode_next = SCSC_MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            mode_reg <= SCSC_MODE_NORMAL;
            vec_reg  <= 1'b0;
            res_reg  <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            vec_reg  <= vec_next;
            res_reg  <= res_next;
        end
    end

    // ------------------------------------------------------------
    // instruction length in machine cycles
    // ------------------------------------------------------------
    always_comb
    begin
        icnt_next = icnt_reg;
        done_next = 1'b0;
        // a zero length is taken as one cycle so every start in normal mode ends
        if (insn_start_in && mode_reg == SCSC_MODE_NORMAL)
            icnt_next = (insn_cycles_in == 4'h0) ? 4'h1 : insn_cycles_in;
        else if (cyc_end_w && icnt_reg != 4'h0)
        begin
            icnt_next = icnt_reg - 4'h1;
            done_next = (icnt_reg == 4'h1);
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            icnt_reg <= 4'h0;
            done_reg <= 1'b0;
        end
        else
        begin
            icnt_reg <= icnt_next;
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------
    // read data, standing for the one cycle after the strobe
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_next = 8'h00;
        if (reg_rd_in)
        begin
            if (is_addr(reg_addr_in, `SCSC_ADDR_CTRL_TWO))
                rdata_next = {sc2_reg[7:4], 4'h0};
            else if (is_addr(reg_addr_in, `SCSC_ADDR_DIVCTL))
                // bits four and three hold no defined value; zero here
                rdata_next = 8'h00;
            else if (is_addr(reg_addr_in, `SCSC_ADDR_STATUS))
                rdata_next = {4'h0, divsel_reg, mode_reg};
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // ------------------------------------------------------------
    // source clocks for peripherals
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_tc
            assign tc_sel[g] = div_w[`SCSC_TAP_TC_BASE + 2*g];
        end
    endgenerate

    // the selected tap leaves through a flip-flop, so it cannot glitch
    always_comb
    begin
        tc_next = tc_sel[{divsel_reg[1], divsel_reg[0]}];
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            tc_reg <= 1'b0;
        else
            tc_reg <= tc_next;
    end

    assign tbt_clk_out      = div_w[`SCSC_TAP_TBT];
    assign watchdog_clk_out = div_w[`SCSC_TAP_WATCHDOG] & watchdog_run_out;
    assign tc_clk_out       = {tc_reg, tc_sel[2:0]};
    assign cpu_run_out      = (mode_reg == SCSC_MODE_NORMAL);
    assign watchdog_run_out = (mode_reg == SCSC_MODE_NORMAL);
    assign periph_run_out   = 1'b1;
    assign wake_vector_out  = vec_reg;
    assign wake_resume_out  = res_reg;
    assign soft_reset_out   = srst_reg;
    assign insn_done_out    = done_reg;
    assign reg_rdata_out    = rdata_reg;
    assign state_out        = st_w;
    assign mode_out         = mode_reg;

endmodule // scsc_clock_control

`default_nettype wire

// ---- src/scsc_defines.svh ----
`ifndef SCSC_DEFINES_SVH
`define SCSC_DEFINES_SVH

// register offsets on the plain port
`define SCSC_ADDR_CTRL_TWO      8'h39
`define SCSC_ADDR_DIVCTL        8'h3A
`define SCSC_ADDR_STATUS        8'h3B

// system control two fields
`define SCSC_SC2_KEEP_BIT       7
`define SCSC_SC2_IDLE_BIT       4
`define SCSC_SC2_RESET_VALUE    8'h80

// divider control fields
`define SCSC_DIV_SEL_LSB        3
`define SCSC_DIV_SEL_MSB        4
`define SCSC_DIV_RESET_VALUE    8'h00

// timing generator shape
`define SCSC_PRESCALE_STAGES    3
`define SCSC_DIVIDER_STAGES     21
`define SCSC_STATES_PER_CYCLE   4
`define SCSC_MAX_INSN_CYCLES    15

// time base, watchdog and timer counter taps in the divider chain
`define SCSC_TAP_TBT            13
`define SCSC_TAP_WATCHDOG       20
`define SCSC_TAP_TC_BASE        1

`endif

// ---- src/scsc_pkg.sv ----
package scsc_pkg;

    typedef enum logic [1:0]
    {
        SCSC_MODE_NORMAL = 2'b00,
        SCSC_MODE_IDLE   = 2'b01,
        SCSC_MODE_WAKE   = 2'b11
    } scsc_mode_t;

    typedef enum logic [1:0]
    {
        SCSC_ST_S0 = 2'b00,
        SCSC_ST_S1 = 2'b01,
        SCSC_ST_S2 = 2'b11,
        SCSC_ST_S3 = 2'b10
    } scsc_state_t;

endpackage

// ---- src/scsc_timing_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scsc_defines.svh"

module scsc_timing_gen
    import scsc_pkg::*;
#(
    parameter int PRE_STAGES = `SCSC_PRESCALE_STAGES,
    parameter int DIV_STAGES = `SCSC_DIVIDER_STAGES
)
(
    input  wire logic                  mclk_in,
    input  wire logic                  sys_rst_in,
    output logic     [PRE_STAGES-1:0]  prescale_out,
    output logic     [DIV_STAGES-1:0]  divider_out,
    output scsc_state_t                state_out,
    output logic                       cycle_end_out
);

    // ------------------------------------------------------------
    // prescaler, divider chain, machine-cycle counter
    // ------------------------------------------------------------
    logic [PRE_STAGES-1:0] pre_reg;
    logic [PRE_STAGES-1:0] pre_next;
    logic [DIV_STAGES-1:0] div_reg;
    logic [DIV_STAGES-1:0] div_next;
    scsc_state_t           st_reg;
    scsc_state_t           st_next;

    generate
        if (PRE_STAGES < 2 || DIV_STAGES < `SCSC_TAP_WATCHDOG + 1)
        begin : g_bad_stages
            $error("scsc_timing_gen: stage counts too small");
        end
    endgenerate

    // free running chain; it never pauses, also not in idle
    always_comb
    begin
        pre_next = pre_reg + {{(PRE_STAGES-1){1'b0}}, 1'b1};
        div_next = div_reg;
        if (&pre_reg)
            div_next = div_reg + {{(DIV_STAGES-1){1'b0}}, 1'b1};
        case (st_reg)
            SCSC_ST_S0: st_next = SCSC_ST_S1;
            SCSC_ST_S1: st_next = SCSC_ST_S2;
            SCSC_ST_S2: st_next = SCSC_ST_S3;
            SCSC_ST_S3: st_next = SCSC_ST_S0;
            default:    st_next = SCSC_ST_S0;
        endcase
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pre_reg <= '0;
            div_reg <= '0;
            st_reg  <= SCSC_ST_S0;
        end
        else
        begin
            pre_reg <= pre_next;
            div_reg <= div_next;
            st_reg  <= st_next;
        end
    end

    assign prescale_out  = pre_reg;
    assign divider_out   = div_reg;
    assign state_out     = st_reg;
    assign cycle_end_out = (st_reg == SCSC_ST_S3);

endmodule // scsc_timing_gen

`default_nettype wire

// ---- verification/scsc_clock_control_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module scsc_clock_control_checker
    import scsc_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        sys_rst_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        periph_irq_in,
    input wire logic        ext_irq_in,
    input wire logic        watchdog_irq_in,
    input wire logic        interrupt_master_enable_in,
    input wire logic        cpu_run_out,
    input wire logic        watchdog_run_out,
    input wire logic        wake_vector_out,
    input wire logic        wake_resume_out,
    input wire logic        soft_reset_out,
    input wire scsc_state_t state_out,
    input wire scsc_mode_t  mode_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    logic sc2_wr;
    assign sc2_wr = reg_wr_in && reg_addr_in == 8'h39;

    property p_cycle;
        state_out == SCSC_ST_S0 |=> state_out == SCSC_ST_S1
            ##1 state_out == SCSC_ST_S2 ##1 state_out == SCSC_ST_S3;
    endproperty
    a_cycle: assert property (p_cycle) else $error("bad state order");
    property p_div_rd;
        reg_rd_in && reg_addr_in == 8'h3A |=> reg_rdata_out[4:3] == 2'b00;
    endproperty
    a_div_rd: assert property (p_div_rd) else $error("select bits seen");
    property p_enter;
        mode_out == SCSC_MODE_NORMAL && sc2_wr && reg_wdata_in[7]
            && reg_wdata_in[4] && !watchdog_irq_in |=> mode_out == SCSC_MODE_IDLE;
    endproperty
    a_enter: assert property (p_enter) else $error("idle not entered");
    property p_cancel;
        mode_out == SCSC_MODE_NORMAL && sc2_wr && watchdog_irq_in
            |=> mode_out == SCSC_MODE_NORMAL;
    endproperty
    a_cancel: assert property (p_cancel) else $error("idle not cancelled");
    property p_only;
        mode_out != SCSC_MODE_IDLE && !(sc2_wr && reg_wdata_in[4])
            |=> mode_out != SCSC_MODE_IDLE;
    endproperty
    a_only: assert property (p_only) else $error("idle without request");
    property p_stop;
        mode_out == SCSC_MODE_IDLE |-> !cpu_run_out && !watchdog_run_out;
    endproperty
    a_stop: assert property (p_stop) else $error("cpu runs in idle");
    property p_wake;
        mode_out == SCSC_MODE_IDLE && (periph_irq_in || ext_irq_in)
            |=> mode_out == SCSC_MODE_WAKE ##1 mode_out == SCSC_MODE_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake from idle");
    property p_vec;
        mode_out == SCSC_MODE_WAKE && interrupt_master_enable_in
            |=> wake_vector_out && !wake_resume_out;
    endproperty
    a_vec: assert property (p_vec) else $error("vector pulse wrong");
    property p_res;
        mode_out == SCSC_MODE_WAKE && !interrupt_master_enable_in
            |=> wake_resume_out && !wake_vector_out;
    endproperty
    a_res: assert property (p_res) else $error("resume pulse wrong");
    property p_srst;
        sc2_wr && !reg_wdata_in[7] |=> soft_reset_out ##1 !soft_reset_out;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse wrong");

    c_idle: cover property (mode_out == SCSC_MODE_IDLE);
    c_vec: cover property (wake_vector_out);
    c_srst: cover property (soft_reset_out);
    c_res: cover property (wake_resume_out);
endmodule // scsc_clock_control_checker

bind scsc_clock_control scsc_clock_control_checker u_chk (.mclk_in,
    .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .periph_irq_in, .ext_irq_in, .watchdog_irq_in,
    .interrupt_master_enable_in, .cpu_run_out, .watchdog_run_out,
    .wake_vector_out, .wake_resume_out, .soft_reset_out, .state_out,
    .mode_out);

`default_nettype wire

// ---- verification/scsc_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module scsc_osc_model
#(
    parameter time HALF_PERIOD = 5ns
)
(
    output logic osc_in_pin_out
);
    // external oscillator feeds the input pin; the output pin stays open
    initial osc_in_pin_out = 1'b0;
    always #HALF_PERIOD osc_in_pin_out = ~osc_in_pin_out;
endmodule // scsc_osc_model

`default_nettype wire

// ---- verification/test_scsc_clock_control.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", w, e, g); end end

module test_scsc_clock_control
    import scsc_pkg::*;
;
    wire         mclk_in;
    logic        sys_rst_in, reg_wr_in, reg_rd_in, periph_irq_in, ext_irq_in;
    logic        watchdog_irq_in, interrupt_master_enable_in, insn_start_in;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [3:0]  insn_cycles_in, tc_clk_out, tc_seen;
    logic        insn_done_out, cpu_run_out, watchdog_run_out, periph_run_out;
    logic        wake_vector_out, wake_resume_out, soft_reset_out;
    logic        tbt_clk_out, watchdog_clk_out;
    scsc_state_t state_out;
    scsc_mode_t  mode_out;
    int          fails, checked, cyc, n, k, m;
    int          lens[3] = '{1, 15, 0};
    scsc_state_t seq[4] = '{SCSC_ST_S0, SCSC_ST_S1, SCSC_ST_S2, SCSC_ST_S3};

    scsc_osc_model osc (.osc_in_pin_out(mclk_in));
    scsc_clock_control dut (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .periph_irq_in, .ext_irq_in,
        .watchdog_irq_in, .interrupt_master_enable_in, .insn_cycles_in,
        .insn_start_in, .insn_done_out, .cpu_run_out, .watchdog_run_out,
        .periph_run_out, .wake_vector_out, .wake_resume_out, .soft_reset_out,
        .tbt_clk_out, .watchdog_clk_out, .tc_clk_out, .state_out, .mode_out);

    // ----------------------------------------
    // bus tasks and closing report
    // ----------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        `CHK("read data", e, reg_rdata_out)
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // a hung wait loop would otherwise never reach the report
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        {reg_wr_in, reg_rd_in, periph_irq_in, ext_irq_in} = 4'h0;
        {watchdog_irq_in, interrupt_master_enable_in, insn_start_in} = 3'h0;
        {reg_addr_in, reg_wdata_in, insn_cycles_in} = 20'h00000;
        {cyc, fails, checked} = '0;
        sys_rst_in = 1'b1;
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #1;
        `CHK("taps", 4'h0, tc_clk_out)
        `CHK("mode", SCSC_MODE_NORMAL, mode_out)
        `CHK("periph run", 1'b1, periph_run_out)
        for (n = 1; n < 9; n++)
        begin
            @(posedge mclk_in);
            #1;
            `CHK("state", seq[n % 4], state_out)
        end
        rd_chk(8'h39, 8'h80);
        rd_chk(8'h77, 8'h00);
        wr_reg(8'h3A, 8'h18);
        rd_chk(8'h3A, 8'h00);
        foreach (lens[i])
        begin
            m = (lens[i] == 0) ? 1 : lens[i];
            @(posedge mclk_in);
            insn_cycles_in <= 4'(lens[i]);
            insn_start_in  <= 1'b1;
            @(posedge mclk_in);
            insn_start_in <= 1'b0;
            for (n = 0; insn_done_out !== 1'b1 && n < 80; n++)
            begin
                @(posedge mclk_in);
                #1;
            end
            `CHK("insn len", 1'b1, n > 4 * m - 4 && n <= 4 * m)
        end
        for (n = 0; n < 2; n++)
        begin
            wr_reg(8'h39, 8'h90);
            #1;
            `CHK("idle mode", SCSC_MODE_IDLE, mode_out)
            `CHK("cpu run", 1'b0, cpu_run_out | watchdog_run_out)
            rd_chk(8'h3B, 8'h0D);
            tc_seen = tc_clk_out;
            for (k = 0; tc_clk_out === tc_seen && k < 300; k++)
                @(posedge mclk_in);
            `CHK("taps in idle", 1'b1, k < 300)
            @(posedge mclk_in);
            interrupt_master_enable_in <= (n == 0);
            ext_irq_in    <= (n == 0);
            periph_irq_in <= (n == 1);
            @(posedge mclk_in);
            ext_irq_in    <= 1'b0;
            periph_irq_in <= 1'b0;
            @(posedge mclk_in);
            #1;
            `CHK("woken", SCSC_MODE_NORMAL, mode_out)
            `CHK("vector", n == 0, wake_vector_out)
            `CHK("resume", n == 1, wake_resume_out)
        end
        @(posedge mclk_in);
        watchdog_irq_in <= 1'b1;
        wr_reg(8'h39, 8'h90);
        #1;
        `CHK("cancelled", SCSC_MODE_NORMAL, mode_out)
        rd_chk(8'h39, 8'h80);
        wr_reg(8'h39, 8'h00);
        #1;
        `CHK("soft reset", 1'b1, soft_reset_out)
        // a second reset in mid-run must clear a chain that has moved
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        `CHK("taps in reset", 4'h0, tc_clk_out)
        `CHK("slow taps", 2'h0, {tbt_clk_out, watchdog_clk_out})
        `CHK("state in reset", SCSC_ST_S0, state_out)
        @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd_chk(8'h39, 8'h80);
        `CHK("mode after reset", SCSC_MODE_NORMAL, mode_out)
        tally_and_finish();
    end
endmodule // test_scsc_clock_control

`default_nettype wire
